// ---- common/hbps_pkg.sv ----
// package: constants for the half-bridge pwm sequencer
package hbps_pkg;
  localparam int unsigned ClkMhz = 40;
  // timing figures in ns, counts derived from the 40 MHz clock
  localparam int unsigned PrechargeNs = 100;
  localparam int unsigned PrechargeCyc = (PrechargeNs * ClkMhz) / 1000;
  localparam int unsigned MinOffNs = 150;
  localparam int unsigned MinOffCyc = (MinOffNs * ClkMhz + 999) / 1000;
  localparam int unsigned ShutdownQualNs = 2500;
  localparam int unsigned ShutdownQualCyc = (ShutdownQualNs * ClkMhz + 999) / 1000;
  localparam int unsigned ModeTransCycles = 128;
  // default switching period in clocks (internal oscillator)
  localparam int unsigned OscPeriodCyc = 160;
  // wishbone register offsets
  localparam logic [7:0] RegCtrl = 8'h00;
  localparam logic [7:0] RegDuty1 = 8'h04;
  localparam logic [7:0] RegDuty2 = 8'h08;
  localparam logic [7:0] RegDead = 8'h0c;
  localparam logic [7:0] RegStatus = 8'h10;
  localparam logic [7:0] RegPeriod = 8'h14;
  // ctrl field positions
  localparam int unsigned CtrlEnBit = 0;
  localparam int unsigned CtrlRunBit = 1;
  localparam logic [31:0] CtrlReset = 32'h0000_0000;
  localparam logic [31:0] DeadReset = 32'h0000_0004;
  typedef enum logic [1:0]
  {
    HBPS_SS_RUN = 2'b00,
    HBPS_SS_DISCH = 2'b01,
    HBPS_SS_OFF = 2'b10
  } hbps_ss_t;
endpackage : hbps_pkg

// ---- rtl/hbps_sequencer.sv ----
// design: per-channel sequencing of a two-channel half-bridge pwm controller
// Functional notes
// (RULE1) mode pin high selects forced conduction
// (RULE2) mode change ramps over 128 switching cycles
// (RULE3) external pulldown on means pulse skip
// (RULE4) overvoltage discharges channel one soft start
// (RULE5) release below discharge threshold, then retry
// (RULE6) overvoltage restart acts on channel one only
// (RULE7) direction flip discharges soft start, restarts
// (RULE8) parallel operation ties direction inputs together
// (RULE9) buck start, low boot: precharge low pulses
// (RULE10) boot undervoltage forces high gate low
// (RULE11) boot undervoltage restarts precharge during running
// (RULE12) boost mode never emits precharge pulses
// (RULE13) programmed dead time from register value
// (RULE14) shutdown pin tied high selects adaptive
// (RULE15) adaptive: turn on after opposite gate low
// (RULE16) qualified shutdown latches until lockout unlatch
// (RULE17) zero duty below soft start offset
// (RULE18) minimum off time in every period
// (RULE19) dead time added to minimum off time
// (RULE20) external sync clock sets switching frequency
// (RULE21) two channel clocks and sync output
// (RULE22) option high 180, low 240 degrees
// (RULE23) mode pin low selects pulse skip
// (RULE24) comparator inputs pass two-flop synchronisers
// (RULE25) shutdown qualification counter restarts on release
//
// Decided for this implementation: register access over Wishbone and the address map.
module hbps_sequencer
  import hbps_pkg::*;
#(
  parameter int unsigned CntW = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // comparator inputs, asynchronous
  input wire logic [1:0] modeAboveTh,
  input wire logic [1:0] ssAboveOffset,
  input wire logic [1:0] ssBelowDischTh,
  input wire logic [1:0] bootUv,
  input wire logic [1:0] highGateLow,
  input wire logic [1:0] lowGateLow,
  input wire logic [1:0] currentZero,
  input wire logic [1:0] direction,
  input wire logic overvoltageProtect,
  input wire logic deadtimeShutdownLow,
  input wire logic deadtimeShutdownHigh,
  input wire logic undervoltageLockoutLow,
  input wire logic syncClockIn,
  input wire logic syncValid,
  input wire logic interleaveOption,
  // outputs
  output logic [1:0] highGate,
  output logic [1:0] lowGate,
  output logic [1:0] softstartDischarge,
  output logic [1:0] forcedConduction,
  output logic channelClockA,
  output logic channelClockB,
  output logic syncClockOut,
  output logic shutdownLatched
);

  localparam int unsigned NSync = 15;

  // two-flop synchronisers for the pin inputs other than gate and soft-start
  logic [NSync-1:0] syncA_q;
  logic [NSync-1:0] syncB_q;
  logic [NSync-1:0] rawIn;
  assign rawIn = {syncClockIn, syncValid, interleaveOption, undervoltageLockoutLow,
                  deadtimeShutdownHigh, deadtimeShutdownLow, overvoltageProtect,
                  direction, currentZero, bootUv, modeAboveTh};
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= rawIn; // see (RULE24)
      syncB_q <= syncA_q;
    end
  end
  logic [1:0] sMode, sBootUv, sZero, sDir;
  logic sOv, sSdLow, sSdHigh, sUvloLow, sOpt, sSyncValid, sSyncIn;
  assign {sSyncIn, sSyncValid, sOpt, sUvloLow, sSdHigh, sSdLow, sOv,
          sDir, sZero, sBootUv, sMode} = syncB_q;
  // the remaining comparators are synchronised separately (gate and soft-start)
  logic [7:0] gA_q, gB_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gA_q <= '0;
      gB_q <= '0;
    end
    else
    begin
      gA_q <= {ssAboveOffset, ssBelowDischTh, highGateLow, lowGateLow}; // see (RULE24)
      gB_q <= gA_q;
    end
  end
  logic [1:0] sSsOff, sSsDisch, sHoLow, sLoLow;
  assign {sSsOff, sSsDisch, sHoLow, sLoLow} = gB_q;

  // registers
  logic [31:0] ctrl_q, dead_q;
  logic [CntW-1:0] duty_q [2];
  logic [CntW-1:0] period_q;
  logic wbReq;
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CtrlReset;
      dead_q <= DeadReset;
      duty_q[0] <= '0;
      duty_q[1] <= '0;
      period_q <= CntW'(OscPeriodCyc);
    end
    else if (wbReq && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        RegCtrl: ctrl_q <= wb_dat_i;
        RegDuty1: duty_q[0] <= wb_dat_i[CntW-1:0];
        RegDuty2: duty_q[1] <= wb_dat_i[CntW-1:0];
        RegDead: dead_q <= wb_dat_i; // see (RULE13)
        RegPeriod: period_q <= wb_dat_i[CntW-1:0];
        default: ;
      endcase
    end
  end

  // single-cycle ack, read data registered
  logic [31:0] status;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i)
      begin
        case (wb_adr_i)
          RegCtrl: wb_dat_o <= ctrl_q;
          RegDuty1: wb_dat_o <= 32'(duty_q[0]);
          RegDuty2: wb_dat_o <= 32'(duty_q[1]);
          RegDead: wb_dat_o <= dead_q;
          RegStatus: wb_dat_o <= status;
          RegPeriod: wb_dat_o <= 32'(period_q);
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // latched emergency shutdown with qualification counter
  logic [15:0] sdCnt_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sdCnt_q <= '0;
      shutdownLatched <= 1'b0;
    end
    else
    begin
      if (!sSdLow)
        sdCnt_q <= '0; // see (RULE25)
      else if (sdCnt_q != 16'(ShutdownQualCyc))
        sdCnt_q <= sdCnt_q + 16'h0001;
      if (sdCnt_q == 16'(ShutdownQualCyc))
        shutdownLatched <= 1'b1; // see (RULE16)
      else if (sUvloLow)
        shutdownLatched <= 1'b0;
    end
  end

  // switching clock: internal period counter, or edges of a valid sync clock
  logic [CntW-1:0] phase_q;
  logic syncPrev_q, periodStart;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      syncPrev_q <= 1'b0;
    else
      syncPrev_q <= sSyncIn;
  end
  logic syncRise;
  assign syncRise = sSyncIn && !syncPrev_q;
  assign periodStart = sSyncValid ? syncRise : (phase_q >= period_q - 1'b1); // see (RULE20)
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      phase_q <= '0;
    else if (periodStart)
      phase_q <= '0;
    else if (phase_q != {CntW{1'b1}})
      phase_q <= phase_q + 1'b1;
  end
  // measured period, used for phase offsets in both clock sources
  logic [CntW-1:0] measPer_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      measPer_q <= CntW'(OscPeriodCyc);
    else if (periodStart)
      measPer_q <= sSyncValid ? phase_q + 1'b1 : period_q;
  end
  // channel two lag: half or two thirds of the period
  logic [CntW-1:0] lagB, lagS, phaseB, phaseS;
  assign lagB = sOpt ? (measPer_q >> 1) : CntW'((32'(measPer_q) * 2) / 3); // see (RULE22)
  assign lagS = sOpt ? (measPer_q >> 2) : CntW'(32'(measPer_q) / 3);
  assign phaseB = (phase_q >= lagB) ? phase_q - lagB : phase_q + measPer_q - lagB;
  assign phaseS = (phase_q >= lagS) ? phase_q - lagS : phase_q + measPer_q - lagS;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      channelClockA <= 1'b0;
      channelClockB <= 1'b0;
      syncClockOut <= 1'b0;
    end
    else
    begin
      // all three at the switching frequency, 50 percent duty
      channelClockA <= phase_q < (measPer_q >> 1); // see (RULE21)
      channelClockB <= phaseB < (measPer_q >> 1);
      syncClockOut <= phaseS < (measPer_q >> 1);
    end
  end
  logic [1:0] chStart;
  assign chStart[0] = periodStart;
  assign chStart[1] = (phase_q == lagB);

  // per-channel sequencing
  logic [1:0] ssOk;
  logic [CntW-1:0] maxOn;
  logic [CntW-1:0] deadCyc;
  assign deadCyc = dead_q[CntW-1:0];
  // minimum off time plus dead time trims the longest on time
  assign maxOn = (measPer_q > CntW'(MinOffCyc) + deadCyc)
                 ? measPer_q - CntW'(MinOffCyc) - deadCyc : '0; // see (RULE18) (RULE19)
  logic adaptive;
  assign adaptive = sSdHigh; // see (RULE14)

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gCh
      hbps_ss_t ss_q;
      logic [7:0] modeCnt_q;
      logic [CntW-1:0] cnt_q, dtCnt_q;
      logic pwmOn, dischReq, buck, prechg, hiReq, loReq, zeroSeen_q;
      logic [7:0] preCnt_q;
      logic prePulse_q;
      logic dirPrev_q;
      // channel one sees overvoltage; channel two only its direction flip
      assign dischReq = (sDir[ch] != dirPrev_q) ||
                        ((ch == 0) && sOv); // see (RULE4) (RULE6) (RULE7)
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          ss_q <= HBPS_SS_OFF;
          dirPrev_q <= 1'b0;
        end
        else
        begin
          dirPrev_q <= sDir[ch];
          case (ss_q)
            HBPS_SS_OFF:
              if (ctrl_q[CtrlEnBit] && !shutdownLatched)
                ss_q <= HBPS_SS_RUN;
            HBPS_SS_RUN:
              if (dischReq || !ctrl_q[CtrlEnBit] || shutdownLatched)
                ss_q <= HBPS_SS_DISCH;
            HBPS_SS_DISCH:
              // hold while overvoltage persists, release below threshold
              if (!((ch == 0) && sOv) && sSsDisch[ch] && !shutdownLatched)
                ss_q <= HBPS_SS_OFF; // see (RULE5)
            default: ss_q <= HBPS_SS_OFF;
          endcase
        end
      end
      assign softstartDischarge[ch] = (ss_q == HBPS_SS_DISCH);
      assign ssOk[ch] = (ss_q == HBPS_SS_RUN) && sSsOff[ch];

      // gradual mode move: count switching cycles toward the pin level
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          modeCnt_q <= '0;
        else if (chStart[ch])
        begin
          // the top count sets bit 7, so the ramp ends in full forced conduction
          if (sMode[ch] && modeCnt_q != 8'(ModeTransCycles)) // see (RULE1) (RULE3)
            modeCnt_q <= modeCnt_q + 8'h01; // see (RULE2)
          else if (!sMode[ch] && modeCnt_q != 8'h00) // see (RULE23)
            modeCnt_q <= modeCnt_q - 8'h01;
        end
      end
      assign forcedConduction[ch] = modeCnt_q[7] ||
        (modeCnt_q != 8'h00 && cnt_q[6:0] < modeCnt_q[6:0]);

      // pwm on time with zero duty below offset, capped by maxOn
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          cnt_q <= '0;
        else if (chStart[ch])
          cnt_q <= '0;
        else if (cnt_q != {CntW{1'b1}})
          cnt_q <= cnt_q + 1'b1;
      end
      assign pwmOn = ssOk[ch] && (cnt_q < duty_q[ch]) && (cnt_q < maxOn); // see (RULE17)
      assign buck = !ctrl_q[CtrlRunBit];
      assign prechg = buck && sBootUv[ch] && ssOk[ch]; // see (RULE9) (RULE11) (RULE12)

      // fixed-width precharge pulse at each period start
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          preCnt_q <= '0;
          prePulse_q <= 1'b0;
        end
        else if (chStart[ch] && prechg)
        begin
          preCnt_q <= 8'(PrechargeCyc - 1);
          prePulse_q <= 1'b1;
        end
        else if (preCnt_q != 8'h00)
          preCnt_q <= preCnt_q - 8'h01;
        else
          prePulse_q <= 1'b0;
      end

      // zero-crossing latch ends rectifier drive in pulse skip
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          zeroSeen_q <= 1'b0;
        else if (chStart[ch])
          zeroSeen_q <= 1'b0;
        else if (sZero[ch])
          zeroSeen_q <= 1'b1;
      end
      assign hiReq = pwmOn && !sBootUv[ch] && !prechg; // see (RULE10)
      assign loReq = prechg ? prePulse_q
                   : (ssOk[ch] && !pwmOn && (forcedConduction[ch] || !zeroSeen_q));

      // dead time: counted delay, or wait for opposite gate low
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          highGate[ch] <= 1'b0;
          lowGate[ch] <= 1'b0;
          dtCnt_q <= '0;
        end
        else
        begin
          if (!hiReq)
            highGate[ch] <= 1'b0;
          if (!loReq)
            lowGate[ch] <= 1'b0;
          // count from the last gate off, so a long idle gap already covers it
          if (highGate[ch] || lowGate[ch])
            dtCnt_q <= '0;
          else if (dtCnt_q != {CntW{1'b1}})
            dtCnt_q <= dtCnt_q + 1'b1;
          if (hiReq && !loReq && !lowGate[ch] &&
              (adaptive ? sLoLow[ch] : dtCnt_q >= deadCyc)) // see (RULE15)
            highGate[ch] <= 1'b1;
          if (loReq && !hiReq && !highGate[ch] &&
              (adaptive ? sHoLow[ch] : dtCnt_q >= deadCyc))
            lowGate[ch] <= 1'b1;
        end
      end
    end
  endgenerate

  assign status = {18'h0_0000, shutdownLatched, sOv, sBootUv, forcedConduction,
                   softstartDischarge, highGate, lowGate, sSyncValid, adaptive};
endmodule : hbps_sequencer

// ---- tb/hbps_seq_props.sv ----
// checker: port properties of the pwm sequencer
module hbps_seq_props
  import hbps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic overvoltageProtect,
  input wire logic deadtimeShutdownHigh,
  input wire logic undervoltageLockoutLow,
  input wire logic [1:0] bootUv,
  input wire logic [1:0] lowGateLow,
  input wire logic [1:0] highGate,
  input wire logic [1:0] lowGate,
  input wire logic [1:0] softstartDischarge,
  input wire logic shutdownLatched
);
  timeunit 1ns;
  timeprecision 100ps;
  // min off plus the reset dead count of 4 caps the on time
  localparam int MaxOn = OscPeriodCyc - MinOffCyc - 4;
  int hiCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // run length of the channel one high drive
  always_ff @(posedge clk)
  begin
    if (!rst_n || highGate[0] != 1'b1)
      hiCnt <= 0;
    else
      hiCnt <= hiCnt + 1;
  end
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  chk_no_overlap: assert property ((highGate & lowGate) == 2'b00)
    else $error("both gates on");
  chk_adapt_order: assert property ($past(deadtimeShutdownHigh, 3) && $rose(highGate[0])
    |-> $past(lowGateLow[0], 3)) else $error("high on before low off");
  chk_max_on: assert property (hiCnt <= MaxOn)
    else $error("high drive too long");
  chk_ov_disch: assert property (overvoltageProtect [*5] |-> softstartDischarge[0])
    else $error("overvoltage without discharge");
  chk_boot_off: assert property (bootUv[0] [*4] |=> !highGate[0])
    else $error("high gate on with low boot");
  chk_sd_gates: assert property (shutdownLatched [*3] |-> (highGate | lowGate) == 2'b00)
    else $error("gates on in shutdown");
  chk_sd_sticky: assert property (!undervoltageLockoutLow [*4] ##0 shutdownLatched
    |=> shutdownLatched) else $error("shutdown dropped");
  cov_sd: cover property (shutdownLatched);
  cov_dir: cover property (softstartDischarge[1]);
  cov_adapt: cover property (deadtimeShutdownHigh && $rose(highGate[0]));
endmodule : hbps_seq_props

bind hbps_sequencer hbps_seq_props chk_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .overvoltageProtect, .deadtimeShutdownHigh, .undervoltageLockoutLow, .bootUv, .lowGateLow,
  .highGate, .lowGate, .softstartDischarge, .shutdownLatched);

// ---- tb/hbps_bridge_model.sv ----
// partner: gate feedback, mode and direction drive, external sync source
module hbps_bridge_model
(
  input wire logic clk,
  input wire logic [1:0] highGate,
  input wire logic [1:0] lowGate,
  input wire logic [1:0] pulldownOn,
  input wire logic parallelDir,
  input wire logic [1:0] dirIn,
  input wire logic [7:0] syncHalf,
  output logic [1:0] highGateLow,
  output logic [1:0] lowGateLow,
  output logic [1:0] modeAboveTh,
  output logic [1:0] direction,
  output logic syncClockIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] hiD = 2'b00;
  logic [1:0] loD = 2'b00;
  int syncCnt = 0;
  // gate voltage trails its drive by a clock, so turn-on must wait
  always @(posedge clk)
  begin
    hiD <= highGate;
    loD <= lowGate;
  end
  assign highGateLow = ~hiD;
  assign lowGateLow = ~loD;
  // pulldown path on pulls the mode pin under its threshold
  assign modeAboveTh = ~pulldownOn;
  // parallel operation drives both direction inputs as one
  assign direction = parallelDir ? {2{dirIn[0]}} : dirIn;
  // sync source, parked low when the half period is zero
  always @(posedge clk)
    syncCnt <= (syncCnt + 1 >= 2 * syncHalf) ? 0 : syncCnt + 1;
  assign syncClockIn = syncHalf != 8'h00 && syncCnt < syncHalf;
endmodule : hbps_bridge_model

// ---- tb/half_bridge_pwm_sequencer_tb_top.sv ----
// testbench: bus, sequencing, shutdown and clock checks of the pwm sequencer
module half_bridge_pwm_sequencer_tb_top
  import hbps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, par = 1'b0;
  logic [7:0] adr = 8'h00, syncHalf = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, datO;
  logic [1:0] ssOff = 2'b00, ssLow = 2'b00, bootUv = 2'b00, pdOn = 2'b11, dirIn = 2'b00;
  logic overvoltage_protect = 1'b0, sdLow = 1'b0, sdHigh = 1'b0, uvLow = 1'b0, syncV = 1'b0, interleave_option = 1'b1;
  logic ack, syncIn, clkA, clkB, sync_clock_out, sdLat, aP, bP;
  logic [1:0] cz = 2'b00, hgL, lgL, modeTh, dirW, hiG, loG, disch, fc;
  int hiTot = 0, loTot = 0;
  int num_errors = 0, checked = 0, cycN = 0, aRise = 0, aPer = 0, bRise = 0, loRun = 0, pcCnt;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  hbps_sequencer dut_u (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .modeAboveTh(modeTh), .ssAboveOffset(ssOff), .ssBelowDischTh(ssLow), .bootUv,
    .highGateLow(hgL), .lowGateLow(lgL), .currentZero(cz), .direction(dirW),
    .overvoltageProtect(overvoltage_protect), .deadtimeShutdownLow(sdLow), .deadtimeShutdownHigh(sdHigh),
    .undervoltageLockoutLow(uvLow), .syncClockIn(syncIn), .syncValid(syncV),
    .interleaveOption(interleave_option), .highGate(hiG), .lowGate(loG), .softstartDischarge(disch),
    .forcedConduction(fc), .channelClockA(clkA), .channelClockB(clkB),
    .syncClockOut(sync_clock_out), .shutdownLatched(sdLat));
  hbps_bridge_model far_u (.clk, .highGate(hiG), .lowGate(loG), .pulldownOn(pdOn),
    .parallelDir(par), .dirIn, .syncHalf, .highGateLow(hgL), .lowGateLow(lgL),
    .modeAboveTh(modeTh), .direction(dirW), .syncClockIn(syncIn));
  // clock edge times and gate pulse widths
  always @(posedge clk)
  begin
    cycN <= cycN + 1;
    aP <= clkA;
    bP <= clkB;
    if (clkA === 1'b1 && aP === 1'b0)
    begin
      aPer <= cycN - aRise;
      aRise <= cycN;
    end
    if (clkB === 1'b1 && bP === 1'b0)
      bRise <= cycN;
    loRun <= (loG[0] === 1'b1) ? loRun + 1 : 0;
    if (loG[0] !== 1'b1 && loRun == PrechargeCyc)
      pcCnt <= pcCnt + 1;
    if (hiG[0] === 1'b1)
      hiTot <= hiTot + 1;
    if (loG[0] === 1'b1)
      loTot <= loTot + 1;
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic checkV(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : checkV
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one classic cycle, held until ack is sampled, then a idle cycle
  task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
    @(posedge clk);
  endtask : wbXfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbXfer(1'b1, a, d, 4'hf, r);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wbXfer(1'b0, a, 32'h0000_0000, 4'hf, r);
    checkV(r, e);
  endtask : rdChk
  // lag of clock b behind clock a, within one clock of the angle
  task automatic lagChk(input logic o);
    int lag, e;
    lag = (bRise - aRise + OscPeriodCyc) % OscPeriodCyc;
    e = o ? OscPeriodCyc / 2 : (OscPeriodCyc * 2 + 1) / 3;
    checkV(32'(lag >= e - 1 && lag <= e + 1), 1);
  endtask : lagChk
  task automatic fcCount(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge clk);
      k += (fc[0] === 1'b1);
    end
  endtask : fcCount
  // reset, then the scenarios in turn
  initial
  begin
    logic [31:0] r, d;
    int k, p;
    void'($urandom(27));
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    rdChk(RegCtrl, CtrlReset);
    rdChk(RegDead, DeadReset);
    rdChk(RegPeriod, 32'(OscPeriodCyc));
    rdChk(8'h20, 32'h0000_0000);
    // random duties; a write without the low lane is dropped
    repeat (4)
    begin
      d = 32'($urandom_range(20, 140));
      wr(RegDuty2, d);
      wbXfer(1'b1, RegDuty2, d + 1, 4'he, r);
      rdChk(RegDuty2, d);
    end
    // duty above the limit; soft start under the offset keeps high off
    wr(RegDuty1, 32'h0000_00c8);
    wr(RegCtrl, 32'h0000_0001);
    k = hiTot;
    tick(400);
    checkV(32'(hiTot == k), 1);
    ssOff <= 2'b11;
    tick(400);
    checkV(32'(hiTot != k), 1);
    // boot undervoltage in buck, then in boost
    bootUv <= 2'b01;
    tick(10);
    k = hiTot;
    p = pcCnt;
    tick(480);
    checkV(32'(hiTot == k), 1);
    checkV(32'(pcCnt >= p + 2), 1);
    bootUv <= 2'b00;
    tick(400);
    checkV(32'(hiTot != k), 1);
    wr(RegCtrl, 32'h0000_0003);
    bootUv <= 2'b01;
    p = pcCnt;
    tick(480);
    checkV(pcCnt - p, 0);
    bootUv <= 2'b00;
    wr(RegCtrl, 32'h0000_0001);
    // overvoltage twice: hold, wait for discharge, release
    repeat (2)
    begin
      overvoltage_protect <= 1'b1;
      tick(8);
      checkV(disch, 2'b01);
      overvoltage_protect <= 1'b0;
      tick(8);
      checkV(disch, 2'b01);
      ssLow <= 2'b01;
      tick(8);
      checkV(disch, 2'b00);
      ssLow <= 2'b00;
      tick(200);
    end
    // direction flips: both tied, then channel two alone
    par <= 1'b1;
    dirIn <= 2'b01;
    tick(8);
    checkV(disch, 2'b11);
    ssLow <= 2'b11;
    tick(8);
    checkV(disch, 2'b00);
    ssLow <= 2'b00;
    tick(200);
    par <= 1'b0;
    tick(8);
    checkV(disch, 2'b10);
    ssLow <= 2'b10;
    tick(8);
    checkV(disch, 2'b00);
    ssLow <= 2'b00;
    sdHigh <= 1'b1;
    tick(200);
    k = hiTot;
    tick(400);
    checkV(32'(hiTot != k), 1);
    sdHigh <= 1'b0;
    tick(500);
    checkV(aPer, OscPeriodCyc);
    lagChk(1'b1);
    interleave_option <= 1'b0;
    tick(500);
    lagChk(1'b0);
    syncHalf <= 8'h46;
    syncV <= 1'b1;
    tick(1500);
    checkV(aPer, 2 * 70);
    syncV <= 1'b0;
    syncHalf <= 8'h00;
    // mode ramps over 128 cycles of a 40-clock period
    wr(RegPeriod, 32'h0000_0028);
    tick(200);
    pdOn <= 2'b10;
    tick(400);
    fcCount(40, k);
    checkV(32'(k < 40), 1);
    tick(128 * 40);
    fcCount(80, k);
    checkV(k, 80);
    checkV(fc[1], 0);
    // a zero crossing stops the rectifier only in pulse skip
    cz <= 2'b01;
    p = loTot;
    tick(200);
    checkV(32'(loTot != p), 1);
    pdOn <= 2'b11;
    tick(130 * 40);
    fcCount(80, k);
    checkV(k, 0);
    p = loTot;
    tick(200);
    checkV(32'(loTot == p), 1);
    cz <= 2'b00;
    // short lows restart the qualification, a long one latches
    repeat (2)
    begin
      sdLow <= 1'b1;
      tick(60);
      sdLow <= 1'b0;
      tick(4);
    end
    checkV(sdLat, 0);
    sdLow <= 1'b1;
    tick(ShutdownQualCyc + 10);
    sdLow <= 1'b0;
    tick(20);
    checkV(sdLat, 1);
    uvLow <= 1'b1;
    tick(5);
    uvLow <= 1'b0;
    tick(5);
    checkV(sdLat, 0);
    wrap_up();
  end
endmodule : half_bridge_pwm_sequencer_tb_top
